// ==== prsd_pkg.sv ====
/*
 * Constants for the clock ratio strap decoder: register map, strap field
 * positions, ratio encodings, frequency windows and reset values.
 * Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
 */
// Function
// - Platform-to-reference ratio from strap bits 0..2: 4, 5, 6; rest reserved.
// - Core-to-platform ratio from strap bits 3..5: 1, 1.5, 2, 2.5, 3.
// - DDR-to-reference ratio from strap bits 7..8: 8, 10, 12; 11 reserved.
// - DDR complex clock equals the DDR data rate, referenced to reference clock.
// - Memory bus clock is half the data rate, within 333 to 400 MHz.
// - DDR clock domain is always asynchronous to the platform clock.
// - DDR monitor statistics not guaranteed when DDR exceeds three times platform.
// - Core derives from platform clock; platform derives from reference clock.
// - Straps sampled during hard reset, latched at release, then pins released.
package prsd_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [3:0] ADDR_STRAP = 4'h0;
	localparam logic [3:0] ADDR_RATIO = 4'h4;
	localparam logic [3:0] ADDR_FREQ = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hc;
	localparam logic [3:0] ADDR_MASK = 4'h0;
	localparam logic [3:0] ADDR_MASK_REG = 4'h0;

	// ==========================================================
	// Strap field layout
	localparam int STRAP_W = 11;
	localparam int PLAT_LSB = 0;
	localparam int CORE_LSB = 3;
	localparam int LOWF_BIT = 6;
	localparam int DDR_LSB = 7;
	localparam int CSPD_BIT = 9;
	localparam int PSPD_BIT = 10;

	// ==========================================================
	// Ratios, scaled by two so that half ratios stay integers
	localparam logic [4:0] PLAT_X2_4 = 5'h08;
	localparam logic [4:0] PLAT_X2_5 = 5'h0a;
	localparam logic [4:0] PLAT_X2_6 = 5'h0c;
	localparam logic [4:0] CORE_X2_10 = 5'h02;
	localparam logic [4:0] CORE_X2_15 = 5'h03;
	localparam logic [4:0] CORE_X2_20 = 5'h04;
	localparam logic [4:0] CORE_X2_25 = 5'h05;
	localparam logic [4:0] CORE_X2_30 = 5'h06;
	localparam logic [4:0] DDR_X2_8 = 5'h10;
	localparam logic [4:0] DDR_X2_10 = 5'h14;
	localparam logic [4:0] DDR_X2_12 = 5'h18;

	// ==========================================================
	// Frequency windows in MHz
	localparam logic [15:0] CORE_MIN = 16'd400;
	localparam logic [15:0] CORE_MAX = 16'd1000;
	localparam logic [15:0] CORE_LOWF = 16'd450;
	localparam logic [15:0] CORE_SLOW = 16'd500;
	localparam logic [15:0] PLAT_MIN = 16'd267;
	localparam logic [15:0] PLAT_MAX = 16'd400;
	localparam logic [15:0] PLAT_SLOW = 16'd300;
	localparam logic [15:0] MCK_MIN = 16'd333;
	localparam logic [15:0] MCK_MAX = 16'd400;
	localparam logic [15:0] REF_DEFAULT = 16'd100;

	// ==========================================================
	// Status and interrupt bits
	localparam int ST_W = 6;
	localparam int ST_CFG_ERR = 0;
	localparam int ST_CORE_RANGE = 1;
	localparam int ST_PLAT_RANGE = 2;
	localparam int ST_DDR_RANGE = 3;
	localparam int ST_STRAP_BAD = 4;
	localparam int ST_PERF_INACC = 5;
	localparam logic [ST_W-1:0] MASK_RESET = 6'h00;

endpackage

// ==== prsd_decoder.sv ====
/*
 * Clock ratio strap decoder. Samples straps during hard reset, latches them
 * at release, decodes the three ratios and checks the frequency windows.
 * Assumes the reference clock figure in MHz is given on ref_mhz_i and that
 * strap pins are synchronous to clk_i.
 */
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module prsd_decoder #(
	parameter logic [15:0] REF_MHZ_DEFAULT = prsd_pkg::REF_DEFAULT
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic hard_reset_in_i,
	input wire logic [prsd_pkg::STRAP_W-1:0] strap_pins_i,
	input wire logic [15:0] ref_mhz_i,
	output logic strap_sample_en_o,
	output logic [4:0] platform_ratio_x2_o,
	output logic [4:0] core_ratio_x2_o,
	output logic [4:0] ddr_ratio_x2_o,
	output logic ddr_async_o,
	output logic config_error_o,
	output logic config_valid_o,
	output logic irq_o,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	// ==========================================================
	// Decode functions
	function automatic logic [4:0] plat_dec(input logic [2:0] c);
		plat_dec = 5'h00;
		unique case (c)
			3'h0: plat_dec = prsd_pkg::PLAT_X2_4;
			3'h1: plat_dec = prsd_pkg::PLAT_X2_5;
			3'h2: plat_dec = prsd_pkg::PLAT_X2_6;
			default: plat_dec = 5'h00;
		endcase
	endfunction

	function automatic logic [4:0] core_dec(input logic [2:0] c);
		core_dec = 5'h00;
		unique case (c)
			3'h2: core_dec = prsd_pkg::CORE_X2_10;
			3'h3: core_dec = prsd_pkg::CORE_X2_15;
			3'h4: core_dec = prsd_pkg::CORE_X2_20;
			3'h5: core_dec = prsd_pkg::CORE_X2_25;
			3'h6: core_dec = prsd_pkg::CORE_X2_30;
			default: core_dec = 5'h00;
		endcase
	endfunction

	function automatic logic [4:0] ddr_dec(input logic [1:0] c);
		ddr_dec = 5'h00;
		unique case (c)
			2'h0: ddr_dec = prsd_pkg::DDR_X2_8;
			2'h1: ddr_dec = prsd_pkg::DDR_X2_10;
			2'h2: ddr_dec = prsd_pkg::DDR_X2_12;
			default: ddr_dec = 5'h00;
		endcase
	endfunction

	// ==========================================================
	// Strap capture
	logic hard_reset_in_d;
	logic [prsd_pkg::STRAP_W-1:0] strap_live;
	logic [prsd_pkg::STRAP_W-1:0] strap;
	logic latched;
	logic [15:0] ref_mhz;
	wire release_edge = hard_reset_in_d && !hard_reset_in_i;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			hard_reset_in_d <= 1'b1;
			strap_live <= '0;
			strap <= '0;
			latched <= 1'b0;
			ref_mhz <= REF_MHZ_DEFAULT;
		end
		else
		begin
			hard_reset_in_d <= hard_reset_in_i;
			if (hard_reset_in_i)
				strap_live <= strap_pins_i;
			if (release_edge)
			begin
				strap <= strap_live;
				ref_mhz <= ref_mhz_i;
				latched <= 1'b1;
			end
			else if (hard_reset_in_i)
				latched <= 1'b0;
		end
	end

	// ==========================================================
	// Ratio decode and frequency computation
	wire [2:0] plat_code = strap[prsd_pkg::PLAT_LSB +: 3];
	wire [2:0] core_code = strap[prsd_pkg::CORE_LSB +: 3];
	wire [1:0] ddr_code = strap[prsd_pkg::DDR_LSB +: 2];
	wire low_core_strap = strap[prsd_pkg::LOWF_BIT];
	wire core_spd_strap = strap[prsd_pkg::CSPD_BIT];
	wire plat_spd_strap = strap[prsd_pkg::PSPD_BIT];
	wire [4:0] plat_x2 = plat_dec(plat_code);
	wire [4:0] core_x2 = core_dec(core_code);
	wire [4:0] ddr_x2 = ddr_dec(ddr_code);
	wire reserved = (plat_x2 == 5'h00) || (core_x2 == 5'h00)
		|| (ddr_x2 == 5'h00);

	// Platform from reference, core from platform
	wire [31:0] plat_f2 = 32'(ref_mhz) * 32'(plat_x2);
	wire [31:0] plat_mhz = {1'b0, plat_f2[31:1]};
	wire [31:0] core_f2 = plat_mhz * 32'(core_x2);
	wire [31:0] core_mhz = {1'b0, core_f2[31:1]};
	// DDR data rate referenced to reference clock; bus clock is half of it
	wire [31:0] ddr_f2 = 32'(ref_mhz) * 32'(ddr_x2);
	wire [31:0] ddr_mhz = {1'b0, ddr_f2[31:1]};
	wire [31:0] mck_mhz = {1'b0, ddr_mhz[31:1]};

	wire core_bad = (core_mhz < 32'(prsd_pkg::CORE_MIN))
		|| (core_mhz > 32'(prsd_pkg::CORE_MAX));
	wire plat_bad = (plat_mhz < 32'(prsd_pkg::PLAT_MIN))
		|| (plat_mhz > 32'(prsd_pkg::PLAT_MAX));
	wire ddr_bad = (mck_mhz < 32'(prsd_pkg::MCK_MIN))
		|| (mck_mhz > 32'(prsd_pkg::MCK_MAX))
		|| (ddr_mhz <= plat_mhz);
	wire strap_bad = (low_core_strap
		&& core_mhz <= 32'(prsd_pkg::CORE_LOWF))
		|| (core_spd_strap
		&& core_mhz <= 32'(prsd_pkg::CORE_SLOW))
		|| (plat_spd_strap
		&& plat_mhz < 32'(prsd_pkg::PLAT_SLOW));
	wire perf_inacc = ddr_mhz > (plat_mhz * 32'd3);

	wire [prsd_pkg::ST_W-1:0] ev_vec = latched ? {perf_inacc, strap_bad,
		ddr_bad & ~reserved, plat_bad & ~reserved, core_bad & ~reserved,
		reserved} : '0;

	// ==========================================================
	// Register bus and interrupt
	logic [prsd_pkg::ST_W-1:0] status;
	logic [prsd_pkg::ST_W-1:0] mask;
	logic [prsd_pkg::ST_W-1:0] ev_prev;
	logic ack;
	wire access = (avs_read || avs_write) && !ack;
	wire rd_status = avs_read && !ack && (avs_address == prsd_pkg::ADDR_STATUS);
	wire wr_mask = avs_write && !ack && (avs_address == 4'h0)
		&& avs_byteenable[0];
	wire [prsd_pkg::ST_W-1:0] ev_rise = ev_vec & ~ev_prev;
	wire [prsd_pkg::ST_W-1:0] next_status =
		(rd_status ? '0 : status) | ev_rise;
	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address)
			prsd_pkg::ADDR_STRAP:
				rd_mux = {16'h0000, 2'h0, latched, 2'h0, strap};
			prsd_pkg::ADDR_RATIO:
				rd_mux = {17'h0, ddr_x2, core_x2, plat_x2};
			prsd_pkg::ADDR_FREQ:
				rd_mux = {core_mhz[15:0], plat_mhz[15:0]};
			prsd_pkg::ADDR_STATUS:
				rd_mux = {20'h0, mask, status};
			default:
				rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			status <= '0;
			mask <= prsd_pkg::MASK_RESET;
			ev_prev <= '0;
			ack <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			ev_prev <= ev_vec;
			status <= next_status;
			ack <= access;
			if (access && avs_read)
				avs_readdata <= rd_mux;
			if (wr_mask)
				mask <= avs_writedata[prsd_pkg::ST_W-1:0];
		end
	end

	// ==========================================================
	// Output registers
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			strap_sample_en_o <= 1'b1;
			platform_ratio_x2_o <= 5'h00;
			core_ratio_x2_o <= 5'h00;
			ddr_ratio_x2_o <= 5'h00;
			ddr_async_o <= 1'b1;
			config_error_o <= 1'b0;
			config_valid_o <= 1'b0;
			irq_o <= 1'b0;
			avs_waitrequest <= 1'b1;
		end
		else
		begin
			strap_sample_en_o <= hard_reset_in_i;
			platform_ratio_x2_o <= plat_x2;
			core_ratio_x2_o <= core_x2;
			ddr_ratio_x2_o <= ddr_x2;
			ddr_async_o <= 1'b1;
			config_error_o <= latched && reserved;
			config_valid_o <= latched && !reserved;
			irq_o <= |(next_status & mask);
			avs_waitrequest <= !access;
		end
	end

endmodule

`default_nettype wire

// ==== prsd_decoder_props.sv ====
/* Port checker for the strap decoder.
   Assumes binding to prsd_decoder, one clock, sync reset. */
`timescale 1ns/100ps
`default_nettype none
module prsd_decoder_props (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic hard_reset_in_i,
	input wire logic strap_sample_en_o,
	input wire logic [4:0] platform_ratio_x2_o,
	input wire logic [4:0] core_ratio_x2_o,
	input wire logic [4:0] ddr_ratio_x2_o,
	input wire logic ddr_async_o,
	input wire logic config_error_o,
	input wire logic config_valid_o,
	input wire logic irq_o
);
	// ==========
	// Properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	property p_async;
		ddr_async_o;
	endproperty
	property p_samp;
		!$past(reset_i) |-> strap_sample_en_o == $past(hard_reset_in_i);
	endproperty
	property p_plat;
		config_valid_o |-> platform_ratio_x2_o inside {5'h08, 5'h0a, 5'h0c};
	endproperty
	property p_core;
		config_valid_o |-> core_ratio_x2_o inside {[5'h02:5'h06]};
	endproperty
	property p_ddr;
		config_valid_o |-> ddr_ratio_x2_o inside {5'h10, 5'h14, 5'h18};
	endproperty
	property p_err;
		config_error_o |-> !config_valid_o && (platform_ratio_x2_o == 5'h00
			|| core_ratio_x2_o == 5'h00 || ddr_ratio_x2_o == 5'h00);
	endproperty
	property p_hold;
		!hard_reset_in_i [*5] |-> $stable(platform_ratio_x2_o)
			&& $stable(ddr_ratio_x2_o);
	endproperty
	property p_done;
		$fell(hard_reset_in_i) ##1 !hard_reset_in_i
			|=> config_valid_o ^ config_error_o;
	endproperty
	a_async: assert property (p_async) else $error("ddr sync");
	a_samp: assert property (p_samp) else $error("sample en");
	a_plat: assert property (p_plat) else $error("plat ratio");
	a_core: assert property (p_core) else $error("core ratio");
	a_ddr: assert property (p_ddr) else $error("ddr ratio");
	a_err: assert property (p_err) else $error("cfg error");
	a_hold: assert property (p_hold) else $error("latch moved");
	a_done: assert property (p_done) else $error("no verdict");
	c_err: cover property (config_error_o);
	c_valid: cover property (config_valid_o);
	c_irq: cover property (irq_o);
endmodule
bind prsd_decoder prsd_decoder_props u_props (.clk_i(clk_i),
	.reset_i(reset_i), .hard_reset_in_i(hard_reset_in_i),
	.strap_sample_en_o(strap_sample_en_o), .ddr_async_o(ddr_async_o),
	.platform_ratio_x2_o(platform_ratio_x2_o), .irq_o(irq_o),
	.core_ratio_x2_o(core_ratio_x2_o), .ddr_ratio_x2_o(ddr_ratio_x2_o),
	.config_error_o(config_error_o), .config_valid_o(config_valid_o));
`default_nettype wire

// ==== prsd_board.sv ====
/* Board strap resistor model.
   Assumes the bench picks ratio codes and reference figure. */
`timescale 1ns/100ps
`default_nettype none
module prsd_board (
	input wire logic sample_en_i,
	input wire logic [8:0] cfg_i,
	input wire logic [15:0] ref_i,
	output logic [10:0] strap_o
);
	// ==========
	// Speed straps follow the chosen frequencies
	int plat;
	int core;
	logic [10:0] val;
	assign plat = int'(ref_i) * (4 + int'(cfg_i[2:0]));
	assign core = plat * int'(cfg_i[5:3]) / 2;
	assign val = {plat >= 300, core > 500, cfg_i[8:7], core > 450,
		cfg_i[5:0]};
	assign strap_o = sample_en_i ? val : ~val;
endmodule
`default_nettype wire

// ==== pll_ratio_strap_decoder_bench.sv ====
/* Self-checking bench for the strap decoder.
   Assumes prsd_decoder, prsd_board and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module pll_ratio_strap_decoder_bench;
	logic clk_i;
	logic reset_i;
	logic hard;
	logic sen;
	logic [8:0] cfg;
	logic [10:0] straps;
	logic [4:0] pr;
	logic [4:0] cr;
	logic [4:0] dr;
	logic asy;
	logic cerr;
	logic cval;
	logic irq;
	logic [3:0] adr;
	logic rd;
	logic wr;
	logic [31:0] wd;
	logic [31:0] q;
	logic [31:0] rdat;
	logic wt;
	int err_total;
	int checks;
	prsd_board u_board (.sample_en_i(sen), .cfg_i(cfg), .ref_i(16'd100),
		.strap_o(straps));
	prsd_decoder u_dut (.clk_i(clk_i), .reset_i(reset_i),
		.hard_reset_in_i(hard), .strap_pins_i(straps), .ref_mhz_i(16'd100),
		.strap_sample_en_o(sen), .platform_ratio_x2_o(pr),
		.core_ratio_x2_o(cr), .ddr_ratio_x2_o(dr), .ddr_async_o(asy),
		.config_error_o(cerr), .config_valid_o(cval), .irq_o(irq),
		.avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
		.avs_waitrequest(wt));
	// ==========
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_i);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wt !== 1'b0 && n < 50);
		q = rdat;
		if (n == 50)
		begin
			err_total++;
			complete_run();
		end
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic boot(input logic [8:0] c);
		@(posedge clk_i);
		cfg <= c;
		hard <= 1'b1;
		repeat (3) @(posedge clk_i);
		hard <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic t_codes();
		logic [4:0] ep;
		logic [4:0] ec;
		logic [4:0] ed;
		for (int i = 0; i < 8; i++)
		begin
			boot({i[1:0], 1'b0, i[2:0], i[2:0]});
			ep = (i < 3) ? 5'(8 + 2 * i) : 5'h00;
			ec = (i >= 2 && i <= 6) ? 5'(i) : 5'h00;
			ed = (i % 4 < 3) ? 5'(16 + 4 * (i % 4)) : 5'h00;
			chk(pr, ep);
			chk(cr, ec);
			chk(dr, ed);
			chk(cerr, ep == 0 || ec == 0 || ed == 0);
			bus(1'b0, 4'h4, 32'h0);
			chk(q, {17'h0, ed, ec, ep});
		end
		$display("codes test done");
	endtask
	task automatic t_valid();
		boot(9'h020);
		chk(cval, 1'b1);
		chk(asy, 1'b1);
		bus(1'b0, 4'h8, 32'h0);
		chk(q, 32'h0320_0190);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h0000_2660);
		bus(1'b0, 4'h2, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, 4'hc, 32'h0);
		bus(1'b0, 4'hc, 32'h0);
		chk(q[5:0], 6'h00);
		boot(9'h022);
		bus(1'b0, 4'hc, 32'h0);
		chk(q[5:0], 6'h06);
		$display("valid test done");
	endtask
	task automatic t_irq(input logic [5:0] m);
		bus(1'b1, 4'h0, {26'h0, m});
		boot(9'h020);
		bus(1'b0, 4'hc, 32'h0);
		chk(q[11:6], m);
		boot(9'h1ff);
		chk(irq, m[0]);
		bus(1'b0, 4'hc, 32'h0);
		chk(q[0], 1'b1);
		repeat (3) @(posedge clk_i);
		chk(irq, 1'b0);
		$display("irq test done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ==========
	// Clock, watchdog and sequence
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (5000) @(posedge clk_i);
		err_total++;
		complete_run();
	end
	initial
	begin
		err_total = 0;
		checks = 0;
		reset_i = 1'b1;
		hard = 1'b0;
		cfg = 9'h0;
		adr = 4'h0;
		rd = 1'b0;
		wr = 1'b0;
		wd = 32'h0;
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		t_codes();
		t_valid();
		t_irq(6'h3f);
		t_irq(6'h00);
		complete_run();
	end
endmodule
`default_nettype wire
